// file: hw/self_id_receive_formatter.sv
`timescale 1ns/1ps
`include "sid_defines.svh"
// self-id receive formatter with wishbone register slave
module self_id_receive_formatter #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire sid_pkg::phy_quad_t phy_in,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [11:0]       wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   irq
);
    import sid_pkg::*;

    wb_req_t     req;
    fmt_state_t  state_r;
    logic [1:0]  ctrl_r;
    logic [1:0]  int_stat_r;
    logic [1:0]  int_mask_r;
    logic        ack_r;
    logic [31:0] rdat_r;
    logic        irq_r;
    logic        rd_pend_r;
    logic        rd_buf_r;

    // sequence tracking
    logic        odd_r;
    logic [31:0] prev_r;
    logic [5:0]  exp_id_r;
    logic [5:0]  last_id_r;
    logic        first_r;
    logic        phy_pkt_r;
    logic [1:0]  spd_r;
    logic [2:0]  err_r;
    logic [2:0]  err_nxt;
    logic [AW:0] wptr_r;
    logic [13:0] count_r;
    logic [13:0] done_count_r;
    logic [2:0]  done_err_r;
    logic        busy_r;

    logic          buf_we;
    logic [AW-1:0] buf_waddr;
    logic [31:0]   buf_wdata;
    logic [AW-1:0] buf_raddr;
    logic [31:0]   buf_rdata;
    token_t        tok;

    logic        wb_hit;
    logic        wb_wr;
    logic        keep_inv;
    logic        is_data;
    logic        store;
    logic        full;
    logic [5:0]  q_id;
    logic        done_evt;
    logic        err_evt;

    assign req       = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                         adr: wb_adr_i, dat: wb_dat_i};
    assign wb_hit    = req.cyc & req.stb & ~ack_r;
    // writes land once, on the ack edge, so a clear cannot swallow a fresh event
    assign wb_wr     = req.cyc & req.stb & req.we & ack_r;
    assign keep_inv  = ctrl_r[`SID_CTRL_KEEP_INV];
    assign is_data   = ~odd_r;
    assign q_id      = phy_in.data[`SID_ID_HI:`SID_ID_LO];
    assign full      = (wptr_r >= (AW+1)'(DEPTH));
    // inverse quadlets go to the buffer only with keep-inverse set
    assign store     = phy_in.valid & (is_data | keep_inv) & ~full;

    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = rdat_r;
    assign irq       = irq_r;

    // ---------------- error classification ----------------
    always_comb begin
        err_nxt = err_r;
        if (err_r == `SID_ERR_NONE && phy_in.valid) begin
            if (odd_r) begin
                if (phy_in.data != ~prev_r) begin
                    err_nxt = `SID_ERR_NOT_INV;
                end
            end else if (phy_in.data[`SID_TAG_HI:`SID_TAG_LO] == `SID_TAG) begin
                if (phy_in.data[`SID_EXT_BIT]) begin
                    if (first_r || q_id != last_id_r) begin
                        err_nxt = `SID_ERR_IN_PKT;
                    end
                end else if (q_id > exp_id_r + 6'h01) begin
                    err_nxt = `SID_ERR_GAPS;
                end else if (q_id == exp_id_r + 6'h01) begin
                    err_nxt = `SID_ERR_LARGE_GAP;
                end else if (q_id != exp_id_r) begin
                    err_nxt = `SID_ERR_PHY_ID;
                end
            end
        end
        if (err_r == `SID_ERR_NONE && phy_in.valid && phy_in.last) begin
            // a sequence must end on the inverse half of a pair
            if (!odd_r) begin
                err_nxt = `SID_ERR_PHASE;
            end else if (!phy_pkt_r &&
                         (prev_r[7:6] == `SID_PARENT_PORT ||
                          prev_r[5:4] == `SID_PARENT_PORT ||
                          prev_r[3:2] == `SID_PARENT_PORT)) begin
                err_nxt = `SID_ERR_CHILD;
            end
        end
    end

    // ---------------- token assembly ----------------
    always_comb begin
        tok                                  = '0;
        tok.token_quadlet_count              = count_r;
        tok.self_id_flag                     = ~phy_pkt_r;
        tok.phy_pkt_flag                     = phy_pkt_r;
        tok.link_control_self_id_error_field = phy_pkt_r ? `SID_ERR_NONE : err_r;
        tok.pad                              = `SID_PAD_NONE;
        tok.spd                              = spd_r;
    end

    // buffer write: token slot first, quadlets after, token written only at close
    always_comb begin
        buf_we    = 1'b0;
        buf_waddr = '0;
        buf_wdata = tok;
        if (state_r == ST_CLOSE) begin
            buf_we    = 1'b1;
            buf_waddr = '0;
            buf_wdata = tok;
        end else if (state_r == ST_RECV && store) begin
            buf_we    = 1'b1;
            buf_waddr = wptr_r[AW-1:0];
            buf_wdata = phy_in.data;
        end
    end

    assign buf_raddr = AW'(req.adr[11:2] - 10'(`SID_ADR_BUF_BASE >> 2));

    sid_buffer #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_buf (
        .clk   (clk),
        .we    (buf_we),
        .waddr (buf_waddr),
        .wdata (buf_wdata),
        .raddr (buf_raddr),
        .rdata (buf_rdata)
    );

    // ---------------- sequence state machine ----------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // disabled: the whole sequence is dropped, not buffered
                    if (phy_in.start && ctrl_r[`SID_CTRL_ENABLE]) begin
                        state_r <= ST_RECV;
                    end
                end
                ST_RECV: begin
                    if (phy_in.valid && phy_in.last) begin
                        state_r <= ST_CLOSE;
                    end
                end
                ST_CLOSE: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            odd_r     <= 1'b0;
            prev_r    <= '0;
            exp_id_r  <= '0;
            last_id_r <= '0;
            first_r   <= 1'b1;
            phy_pkt_r <= 1'b0;
            spd_r     <= `SID_SPD_100;
            err_r     <= `SID_ERR_NONE;
            wptr_r    <= '0;
            count_r   <= '0;
        end else if (state_r == ST_IDLE && phy_in.start) begin
            odd_r     <= 1'b0;
            exp_id_r  <= '0;
            first_r   <= 1'b1;
            phy_pkt_r <= 1'b0;
            spd_r     <= phy_in.spd;
            err_r     <= `SID_ERR_NONE;
            // entry 0 reserved for the control token
            wptr_r    <= (AW+1)'(1);
            count_r   <= '0;
        end else if (state_r == ST_RECV && phy_in.valid) begin
            odd_r  <= ~odd_r;
            prev_r <= phy_in.data;
            err_r  <= err_nxt;
            if (is_data) begin
                first_r <= 1'b0;
                if (first_r && phy_in.data[`SID_TAG_HI:`SID_TAG_LO] != `SID_TAG) begin
                    phy_pkt_r <= 1'b1;
                end
                if (!phy_in.data[`SID_EXT_BIT]) begin
                    last_id_r <= q_id;
                    exp_id_r  <= q_id + 6'h01;
                end
            end
            if (store) begin
                wptr_r  <= wptr_r + (AW+1)'(1);
                count_r <= count_r + 14'h0001;
            end
        end
    end

    assign done_evt = (state_r == ST_CLOSE);
    assign err_evt  = done_evt & (tok.link_control_self_id_error_field != `SID_ERR_NONE);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_count_r <= '0;
            done_err_r   <= `SID_ERR_NONE;
            busy_r       <= 1'b0;
        end else begin
            busy_r <= (state_r != ST_IDLE);
            if (done_evt) begin
                done_count_r <= count_r;
                done_err_r   <= tok.link_control_self_id_error_field;
            end
        end
    end

    // ---------------- registers ----------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r     <= `SID_CTRL_RESET;
            int_mask_r <= `SID_MASK_RESET;
        end else if (wb_wr && req.sel[0]) begin
            if (req.adr == 12'(`SID_ADR_CTRL)) begin
                ctrl_r <= req.dat[1:0];
            end
            if (req.adr == 12'(`SID_ADR_INT_MASK)) begin
                int_mask_r <= req.dat[1:0];
            end
        end
    end

    // set wins over a same-cycle write-one-to-clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            int_stat_r <= '0;
        end else begin
            int_stat_r <= (int_stat_r
                           & ~((wb_wr && req.sel[0] && req.adr == 12'(`SID_ADR_INT_STAT))
                               ? req.dat[1:0] : 2'b00))
                          | {err_evt, done_evt};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(int_stat_r & int_mask_r);
        end
    end

    // classic wishbone: ack two cycles after request for every address
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_r     <= 1'b0;
            rd_pend_r <= 1'b0;
            rd_buf_r  <= 1'b0;
            rdat_r    <= '0;
        end else begin
            rd_pend_r <= wb_hit & ~rd_pend_r;
            ack_r     <= rd_pend_r;
            rd_buf_r  <= req.adr >= `SID_ADR_BUF_BASE &&
                         req.adr < `SID_ADR_BUF_BASE + 12'(DEPTH * 4);
            if (rd_pend_r) begin
                if (rd_buf_r) begin
                    rdat_r <= buf_rdata;
                end else begin
                    case (req.adr)
                        12'(`SID_ADR_CTRL):     rdat_r <= {30'h0000_0000, ctrl_r};
                        12'(`SID_ADR_STATUS):   rdat_r <= {12'h000, done_count_r, 2'b00,
                                                           done_err_r, busy_r};
                        12'(`SID_ADR_INT_STAT): rdat_r <= {30'h0000_0000, int_stat_r};
                        12'(`SID_ADR_INT_MASK): rdat_r <= {30'h0000_0000, int_mask_r};
                        default:                rdat_r <= 32'h0000_0000;
                    endcase
                end
            end else begin
                rdat_r <= 32'h0000_0000;
            end
        end
    end

endmodule : self_id_receive_formatter

// file: hw/sid_defines.svh
// offsets, field positions, reset values and codes for the self-id formatter
//
// What this block does
// - enable on, keep-inverse off: store only each first quadlet plus control token.
// - every stored self-id sequence is accompanied by a packet control token.
// - token quadlet count field holds the stored size in quadlets.
// - token self-id flag is 1 when the token belongs to self-id data.
// - token phy-packet flag is 1 when the token belongs to a phy packet.
// - detected self-id error code goes into the three-bit token error field.
// - token pad field is always 00: no padding bytes are appended to the stored packet.
// - speed code: 00 100M, 01 200M, 10 400M, 11 undefined.
// - keep-inverse on: each data quadlet stored, directly followed by its inverse.
// - after bus reset: one token, then the nodes' quadlets in phy-number order, up to DEPTH-1 entries.
// - enable off discards self-id; enable and keep-inverse on store both quadlets.
// - error codes 000 none through 111 quadlet not inverse of prior.
`ifndef SID_DEFINES_SVH
`define SID_DEFINES_SVH

`define SID_ADR_CTRL       8'h00
`define SID_ADR_STATUS     8'h04
`define SID_ADR_INT_STAT   8'h08
`define SID_ADR_INT_MASK   8'h0C
`define SID_ADR_BUF_BASE   12'h100

`define SID_CTRL_ENABLE    0
`define SID_CTRL_KEEP_INV  1
`define SID_INT_DONE       0
`define SID_INT_ERROR      1
`define SID_CTRL_RESET     2'b00
`define SID_MASK_RESET     2'b00

`define SID_TAG            2'b10
`define SID_TAG_HI         31
`define SID_TAG_LO         30
`define SID_ID_HI          29
`define SID_ID_LO          24
`define SID_EXT_BIT        23
`define SID_PARENT_PORT    2'b10

`define SID_ERR_NONE       3'b000
`define SID_ERR_CHILD      3'b001
`define SID_ERR_PHY_ID     3'b010
`define SID_ERR_PHASE      3'b011
`define SID_ERR_GAPS       3'b100
`define SID_ERR_LARGE_GAP  3'b101
`define SID_ERR_IN_PKT     3'b110
`define SID_ERR_NOT_INV    3'b111

`define SID_SPD_100        2'b00
`define SID_PAD_NONE       2'b00

`endif

// file: hw/sid_pkg.sv
// types shared by the self-id formatter files
package sid_pkg;

    typedef struct packed {
        logic [1:0]  rsvd_hi;
        logic [13:0] token_quadlet_count;
        logic        self_id_flag;
        logic        phy_pkt_flag;
        logic [2:0]  rsvd_mid;
        logic [2:0]  link_control_self_id_error_field;
        logic [1:0]  pad;
        logic [1:0]  spd;
        logic [3:0]  rsvd_lo;
    } token_t;

    typedef struct packed {
        logic        start;
        logic        valid;
        logic        last;
        logic [1:0]  spd;
        logic [31:0] data;
    } phy_quad_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RECV,
        ST_CLOSE
    } fmt_state_t;

endpackage : sid_pkg

// file: hw/sid_buffer.sv
`timescale 1ns/1ps
// receive data buffer: one write port, one read port
module sid_buffer #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [31:0]   wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [31:0]   rdata
);
    logic [31:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read, no reset: contents are undefined until written
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end

endmodule : sid_buffer

// file: sim/self_id_receive_formatter_sva.sv
// port-level assertions for the self-id formatter
`timescale 1ns/1ps
module self_id_receive_formatter_sva #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire sid_pkg::phy_quad_t phy_in,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [11:0]        wb_adr_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic               irq
);
    import sid_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_ack_latency: assert property ($rose(wb_stb_i) |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o)
        else $error("ack not two cycles after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> wb_cyc_i && $past(wb_stb_i, 2))
        else $error("ack without request");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_unmapped_zero: assert property ($rose(wb_stb_i) && !wb_we_i && wb_adr_i == 12'h040 |-> ##2 wb_dat_o == '0)
        else $error("unmapped read not zero");
    a_token_shape: assert property ($rose(wb_stb_i) && !wb_we_i && wb_adr_i == 12'h100 |-> ##2
        wb_dat_o[31:30] == 2'b00 && wb_dat_o[15] != wb_dat_o[14] && wb_dat_o[7:6] == 2'b00 && wb_dat_o[3:0] == 4'h0)
        else $error("token reserved, flag or pad bits wrong");
    a_irq_rise: assert property ($rose(irq) |-> $past(phy_in.valid && phy_in.last, 3) ||
        $past(phy_in.valid && phy_in.last, 4) || $past(wb_stb_i && wb_we_i && wb_adr_i == 12'h00c, 2))
        else $error("irq rose without sequence end or mask write");
    a_irq_fall: assert property ($fell(irq) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i, 2))
        else $error("irq fell without a write");
    a_irq_reset: assert property (disable iff (1'b0) !rst_n |=> !irq)
        else $error("irq high after reset");
    c_irq_rise: cover property ($rose(irq));
    c_irq_fall: cover property ($fell(irq));
    c_seq_end: cover property (phy_in.valid && phy_in.last);
endmodule : self_id_receive_formatter_sva

bind self_id_receive_formatter self_id_receive_formatter_sva #(.DEPTH(DEPTH), .AW(AW)) u_sva (
    .clk(clk), .rst_n(rst_n), .phy_in(phy_in), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq(irq)
);

// file: sim/sid_phy_model.sv
// cable phy stand-in feeding self-id sequences to the formatter
`timescale 1ns/1ps
module sid_phy_model (
    input  wire logic          clk,
    output sid_pkg::phy_quad_t phy_in
);
    import sid_pkg::*;
    initial phy_in = '0;
    // released lines toggle so no stale quadlet looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            phy_in.start <= 1'b0;
            phy_in.valid <= 1'b0;
            phy_in.last  <= 1'b0;
            phy_in.spd   <= ~phy_in.spd;
            phy_in.data  <= ~phy_in.data;
        end
    endtask : idle
    task automatic beat(input logic [31:0] q, input logic lst);
        @(posedge clk);
        phy_in.start <= 1'b0;
        phy_in.valid <= 1'b1;
        phy_in.last  <= lst;
        phy_in.data  <= q;
    endtask : beat
    // one packet per node, data then inverse, paced at random
    task automatic send_seq(input logic [1:0] spd, input logic [31:0] q[$], input bit bad_inv);
        @(posedge clk);
        phy_in.start <= 1'b1;
        phy_in.spd   <= spd;
        foreach (q[i]) begin
            idle($urandom_range(2));
            beat(q[i], 1'b0);
            idle($urandom_range(1));
            beat(~q[i] ^ 32'(bad_inv && i == q.size() - 1), i == q.size() - 1);
        end
        idle(1);
    endtask : send_seq
endmodule : sid_phy_model

// file: sim/self_id_receive_formatter_bench.sv
// self-checking bench for the self-id receive formatter
`timescale 1ns/1ps
`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin mismatches++; $display("Error %0t: got %h exp %h", $time, g, e); end \
end
module self_id_receive_formatter_bench;
    import sid_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    phy_quad_t   phy_in;
    wb_req_t     req = '0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq;
    logic [31:0] d;
    logic [31:0] last_tok;
    logic [11:0] rz[5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h040};
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always #20 clk = ~clk;

    self_id_receive_formatter #(.DEPTH(64), .AW(6)) dut (
        .clk(clk), .rst_n(rst_n), .phy_in(phy_in), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .irq(irq)
    );
    sid_phy_model phy (.clk(clk), .phy_in(phy_in));

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    // classic cycle; read data lands in d
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] wd);
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wd};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        d = wb_dat_o;
        req <= '0;
    endtask : wb

    task automatic run_seq(input bit en, input bit keep, input logic [1:0] spd, input int nodes, input int flaw,
                           input logic [1:0] mask);
        logic [31:0] q[$];
        logic [31:0] ex[$];
        logic [2:0]  err;
        int          id;
        err = (flaw == 1) ? 3'b111 : (flaw == 2) ? 3'b101 : 3'b000;
        for (int i = 0; i < nodes; i++) begin
            id = (flaw == 2 && i > 0) ? i + 1 : i;
            // flaw 3: a phy packet, tagged other than self-id
            q.push_back({(flaw == 3) ? 2'b01 : 2'b10, id[5:0], 1'b0, 15'($urandom), 6'h3f, 2'b00});
            ex.push_back(q[i]);
            if (keep) ex.push_back(~q[i] ^ 32'(flaw == 1 && i == nodes - 1));
        end
        wb(1'b1, 12'h00c, {30'h0, mask});
        wb(1'b1, 12'h000, {30'h0, keep, en});
        phy.send_seq(spd, q, flaw == 1);
        if (en) begin
            last_tok = {2'b00, 14'(ex.size()), (flaw == 3) ? 2'b01 : 2'b10, 3'b000, err, 2'b00, spd, 4'h0};
            do wb(1'b0, 12'h008, '0); while (d[0] !== 1'b1);
            `CHK(d, {30'h0, err != 3'b000, 1'b1})
            `CHK(irq, |({err != 3'b000, 1'b1} & mask))
            wb(1'b0, 12'h004, '0);
            `CHK(d, {12'h000, 14'(ex.size()), 2'b00, err, 1'b0})
            wb(1'b0, 12'h100, '0);
            `CHK(d, last_tok)
            foreach (ex[i]) begin
                wb(1'b0, 12'(32'h104 + 4 * i), '0);
                `CHK(d, ex[i])
            end
            wb(1'b1, 12'h008, 32'h0000_0003);
        end else begin
            repeat (6) @(posedge clk);
            wb(1'b0, 12'h100, '0);
            `CHK(d, last_tok)
        end
        wb(1'b0, 12'h008, '0);
        `CHK(d, 32'h0000_0000)
        `CHK(irq, 1'b0)
        $display("test done: en %0d keep %0d nodes %0d flaw %0d", en, keep, nodes, flaw);
    endtask : run_seq

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        void'($urandom(32'h0000_0701));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b1, 12'h040, '1);
        foreach (rz[i]) begin
            wb(1'b0, rz[i], '0);
            `CHK(d, 32'h0000_0000)
        end
        $display("test done: reset values");
        // the phy always sends self-id at the base rate
        for (int t = 0; t < 6; t++) run_seq(1'b1, 1'(t % 2), 2'b00, 1 + t % 3, t % 3, 2'(t % 4));
        run_seq(1'b1, 1'b0, 2'b00, 1, 3, 2'b01);
        run_seq(1'b0, 1'b1, 2'b00, 2, 0, 2'b11);
        close_out();
    end
endmodule : self_id_receive_formatter_bench
